// ==== qpc_chk.sv ====
// Port-level assertion checker for the quadrature position counter
`timescale 1ns/1ps
`include "qpc_defs.vh"
module qpc_chk (
    input logic        aclk,
    input logic        aresetn,
    input logic [5:0]  s_axi_awaddr,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0]  s_axi_wstrb,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        phase_a_input,
    input logic        phase_b_input,
    input logic        count_direction,
    input logic        irq
);
    reg  [2:0] mode_ff;
    reg  [3:0] quiet_ff;
    wire       wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Shadow of the mode field and cycles since a phase pin moved
    always @(posedge aclk) begin
        if (!aresetn) begin
            mode_ff  <= `QPC_RST_MODE;
            quiet_ff <= 4'h0;
        end else begin
            if (wr_take && s_axi_awaddr[5:2] == `QPC_OFS_CTRL && s_axi_wstrb[1])
                mode_ff <= s_axi_wdata[10:8];
            if ($changed({phase_a_input, phase_b_input}))
                quiet_ff <= 4'h0;
            else if (quiet_ff != 4'hf)
                quiet_ff <= quiet_ff + 4'h1;
        end
    end

    property p_fwd_a;
        $rose(phase_a_input) && !phase_b_input && mode_ff[2] |-> ##[2:5] count_direction;
    endproperty
    a_fwd_a: assert property (p_fwd_a) else $error("no forward after A led B");
    property p_rev_a;
        $rose(phase_a_input) && phase_b_input && mode_ff[2] |-> ##[2:5] !count_direction;
    endproperty
    a_rev_a: assert property (p_rev_a) else $error("no reverse after A lagged B");
    property p_fwd_b;
        $rose(phase_b_input) && phase_a_input && mode_ff[2:1] == 2'h3 |-> ##[2:5] count_direction;
    endproperty
    a_fwd_b: assert property (p_fwd_b) else $error("B edge gave wrong direction");
    property p_hold;
        quiet_ff > 4'h5 |-> $stable(count_direction);
    endproperty
    a_hold: assert property (p_hold) else $error("direction moved with quiet pins");
    property p_sync;
        $changed(count_direction) |-> quiet_ff >= 4'h2;
    endproperty
    a_sync: assert property (p_sync) else $error("direction moved before sync delay");
    property p_rd;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd: assert property (p_rd) else $error("read data late");
    property p_wr;
        wr_take |-> ##2 s_axi_bvalid;
    endproperty
    a_wr: assert property (p_wr) else $error("write response late");
    property p_rdone;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
    endproperty
    a_rdone: assert property (p_rdone) else $error("read channel not freed");

    // Main scenarios reached
    c_irq: cover property ($rose(irq));
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `QPC_RESP_SLVERR);
    c_rev: cover property ($fell(count_direction));
endmodule

bind qpc_top qpc_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .phase_a_input(phase_a_input),
    .phase_b_input(phase_b_input), .count_direction(count_direction), .irq(irq)
);

// ==== qpc_decode.v ====
// Quadrature decoder: count pulses, count direction and index edge
`timescale 1ns/1ps
module qpc_decode (
    input  wire aclk,
    input  wire aresetn,
    input  wire enable,
    input  wire x4_mode,
    input  wire phase_a,
    input  wire phase_b,
    input  wire index_in,
    output reg  count_pulse_ff,
    output reg  count_up_ff,
    output reg  direction_ff,
    output reg  index_rise_ff
);
    reg  a_prev_ff;
    reg  b_prev_ff;
    reg  i_prev_ff;
    wire a_edge;
    wire b_edge;
    reg  nxt_up;

    assign a_edge = phase_a ^ a_prev_ff;
    assign b_edge = phase_b ^ b_prev_ff;

    // Direction: A leading B counts up, A lagging B counts down
    always @* begin
        nxt_up = direction_ff;
        if (a_edge)
            nxt_up = phase_a ^ phase_b;
        else if (b_edge)
            nxt_up = ~(phase_a ^ phase_b);
    end

    // Edge history and registered decode results
    always @(posedge aclk) begin
        if (!aresetn) begin
            a_prev_ff      <= 1'b0;
            b_prev_ff      <= 1'b0;
            i_prev_ff      <= 1'b0;
            count_pulse_ff <= 1'b0;
            count_up_ff    <= 1'b1;
            direction_ff   <= 1'b1;
            index_rise_ff  <= 1'b0;
        end else begin
            a_prev_ff      <= phase_a;
            b_prev_ff      <= phase_b;
            i_prev_ff      <= index_in;
            // x2 counts A edges only, x4 counts both phases
            count_pulse_ff <= enable & (a_edge | (x4_mode & b_edge));
            count_up_ff    <= nxt_up;
            direction_ff   <= nxt_up;
            index_rise_ff  <= enable & index_in & ~i_prev_ff;
        end
    end
endmodule

// ==== qpc_defs.vh ====
// Constants for the quadrature position counter: offsets, fields, resets, mode codes
`ifndef QPC_DEFS_VH
`define QPC_DEFS_VH

// Register word indices on the AXI4-Lite bus; byte address is four times the index
`define QPC_OFS_CTRL        4'h0
`define QPC_OFS_FILT        4'h1
`define QPC_OFS_POS         4'h2
`define QPC_OFS_MAX         4'h3
`define QPC_OFS_STAT        4'h4
`define QPC_OFS_MASK        4'h5

// Encoder control register fields
`define QPC_CTRL_ERR_BIT    15
`define QPC_CTRL_DIR_BIT    11
`define QPC_CTRL_MODE_HI    10
`define QPC_CTRL_MODE_LO    8
`define QPC_CTRL_IRST_BIT   2

// Filter control register fields
`define QPC_FILT_COUNT_ERROR_IRQ_DISABLE_BIT   8

// Interrupt status and mask bit positions
`define QPC_IRQ_ERR         0
`define QPC_IRQ_INDEX       1
`define QPC_IRQ_MATCH       2
`define QPC_IRQ_W           3

// Mode codes
`define QPC_MODE_X2_INDEX   3'h4
`define QPC_MODE_X2_MATCH   3'h5
`define QPC_MODE_X4_INDEX   3'h6
`define QPC_MODE_X4_MATCH   3'h7

// Reset values and the all-ones compare value
`define QPC_RST_MODE        3'h0
`define QPC_RST_POS         16'h0000
`define QPC_RST_MAX         16'hffff
`define QPC_ALL_ONES        16'hffff

// AXI responses
`define QPC_RESP_OKAY       2'h0
`define QPC_RESP_SLVERR     2'h2

`endif

// ==== qpc_enc_model.sv ====
// Behavioural incremental encoder driving the phase and index pins
`timescale 1ns/1ps
module qpc_enc_model (
    input  wire logic aclk,
    input  wire logic step,
    input  wire logic fwd,
    input  wire logic mark,
    output logic      phase_a,
    output logic      phase_b,
    output logic      index_out
);
    logic [1:0] pos_ff = 2'h0;
    logic [1:0] nxt_pos;

    // Gray order 00,10,11,01 of (A,B): forward means A leads B
    assign nxt_pos = fwd ? pos_ff + 2'h1 : pos_ff - 2'h1;
    assign phase_a = pos_ff[0] ^ pos_ff[1];
    assign phase_b = pos_ff[1];

    // One state per request; index only where both phases are low
    initial index_out = 1'h0;
    always @(posedge aclk) begin
        if (step) begin
            pos_ff    <= nxt_pos;
            index_out <= mark && nxt_pos == 2'h0;
        end
    end
endmodule

// ==== qpc_sync.v ====
// Two-flop synchronisers for the encoder input pins
`timescale 1ns/1ps
module qpc_sync #(
    parameter WIDTH = 3
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    genvar i;

    // One two-stage chain per pin; stage one feeds only stage two
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_chain
            reg meta_ff;
            reg sync_ff;
            always @(posedge aclk) begin
                if (!aresetn) begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                end else begin
                    meta_ff <= async_in[i];
                    sync_ff <= meta_ff;
                end
            end
            assign sync_out[i] = sync_ff;
        end
    endgenerate
endmodule

// ==== qpc_top.v ====
// Quadrature position counter with AXI4-Lite registers and interrupt
`timescale 1ns/1ps
`include "qpc_defs.vh"
module qpc_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [5:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [5:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        phase_a_input,
    input  wire        phase_b_input,
    input  wire        index_input,
    output reg         count_direction,
    output reg         irq
);
    // Register state
    reg  [2:0]  encoder_mode_field_ff;
    reg         index_reset_enable_ff;
    reg         count_error_flag_ff;
    reg         count_error_irq_disable_ff;
    reg  [15:0] position_count_ff;
    reg  [15:0] maximum_count_ff;
    reg  [`QPC_IRQ_W-1:0] irq_status_ff;
    reg  [`QPC_IRQ_W-1:0] irq_mask_ff;

    // Bus capture state
    reg         aw_have_ff;
    reg         w_have_ff;
    reg  [3:0]  aw_index_ff;
    reg  [31:0] wdata_ff;
    reg  [3:0]  wstrb_ff;

    // Synchronised pins and decoder outputs
    wire [2:0]  pins_sync;
    wire        cnt_pulse;
    wire        cnt_up;
    wire        dir_now;
    wire        index_rise;

    // Mode decode
    wire        enc_on;
    wire        x4_mode;
    wire        index_mode;
    wire        match_mode;

    // Next values
    reg  [15:0] nxt_pos;
    reg         nxt_err;
    reg  [`QPC_IRQ_W-1:0] nxt_set;
    reg  [15:0] stepped;
    wire        wr_go;
    wire        wr_ctrl;
    wire        wr_filt;
    wire        wr_pos;
    wire        wr_max;
    wire        wr_stat;
    wire        wr_mask;
    wire        wr_ok;
    wire [15:0] max_plus_one;

    // Merge byte lanes of the write data into a 16-bit register
    function [15:0] merge16;
        input [15:0] old_val;
        input [31:0] data;
        input [3:0]  strb;
        begin
            merge16 = old_val;
            if (strb[0])
                merge16[7:0] = data[7:0];
            if (strb[1])
                merge16[15:8] = data[15:8];
        end
    endfunction

    // True for the two index-reset mode codes
    function is_index_mode;
        input [2:0] mode;
        begin
            is_index_mode = (mode == `QPC_MODE_X2_INDEX) || (mode == `QPC_MODE_X4_INDEX);
        end
    endfunction

    // True for the two maximum-match mode codes
    function is_match_mode;
        input [2:0] mode;
        begin
            is_match_mode = (mode == `QPC_MODE_X2_MATCH) || (mode == `QPC_MODE_X4_MATCH);
        end
    endfunction

    // Read value of one register index
    function [31:0] read_reg;
        input [3:0] idx;
        begin
            read_reg = 32'h0000_0000;
            case (idx)
                `QPC_OFS_CTRL: begin
                    read_reg[`QPC_CTRL_ERR_BIT]  = count_error_flag_ff;
                    read_reg[`QPC_CTRL_DIR_BIT]  = dir_now;
                    read_reg[`QPC_CTRL_MODE_HI:`QPC_CTRL_MODE_LO] = encoder_mode_field_ff;
                    read_reg[`QPC_CTRL_IRST_BIT] = index_reset_enable_ff;
                end
                `QPC_OFS_FILT: read_reg[`QPC_FILT_COUNT_ERROR_IRQ_DISABLE_BIT] = count_error_irq_disable_ff;
                `QPC_OFS_POS:  read_reg[15:0] = position_count_ff;
                `QPC_OFS_MAX:  read_reg[15:0] = maximum_count_ff;
                `QPC_OFS_STAT: read_reg[`QPC_IRQ_W-1:0] = irq_status_ff;
                `QPC_OFS_MASK: read_reg[`QPC_IRQ_W-1:0] = irq_mask_ff;
                default:       read_reg = 32'h0000_0000;
            endcase
        end
    endfunction

    // Register index is known when it is one of the six words
    function idx_known;
        input [3:0] idx;
        begin
            idx_known = (idx <= `QPC_OFS_MASK);
        end
    endfunction

    // Encoder pins into the clock domain
    qpc_sync #(
        .WIDTH    (3)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({index_input, phase_b_input, phase_a_input}),
        .sync_out (pins_sync)
    );

    // Mode field steers the decoder and the counter
    assign enc_on     = encoder_mode_field_ff[2];
    assign x4_mode    = encoder_mode_field_ff[1];
    assign index_mode = is_index_mode(encoder_mode_field_ff);
    assign match_mode = is_match_mode(encoder_mode_field_ff);

    qpc_decode u_decode (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .enable         (enc_on),
        .x4_mode        (x4_mode),
        .phase_a        (pins_sync[0]),
        .phase_b        (pins_sync[1]),
        .index_in       (pins_sync[2]),
        .count_pulse_ff (cnt_pulse),
        .count_up_ff    (cnt_up),
        .direction_ff   (dir_now),
        .index_rise_ff  (index_rise)
    );

    // Write decode
    assign wr_go   = aw_have_ff & w_have_ff & ~s_axi_bvalid;
    assign wr_ok   = idx_known(aw_index_ff);
    assign wr_ctrl = wr_go & (aw_index_ff == `QPC_OFS_CTRL);
    assign wr_filt = wr_go & (aw_index_ff == `QPC_OFS_FILT);
    assign wr_pos  = wr_go & (aw_index_ff == `QPC_OFS_POS);
    assign wr_max  = wr_go & (aw_index_ff == `QPC_OFS_MAX);
    assign wr_stat = wr_go & (aw_index_ff == `QPC_OFS_STAT);
    assign wr_mask = wr_go & (aw_index_ff == `QPC_OFS_MASK);
    assign max_plus_one = maximum_count_ff + 16'h0001;

    // Counter next value, error detection and interrupt events
    always @* begin
        nxt_pos = position_count_ff;
        nxt_err = 1'b0;
        nxt_set = {`QPC_IRQ_W{1'b0}};
        stepped = cnt_up ? position_count_ff + 16'h0001
                         : position_count_ff - 16'h0001;
        if (index_rise) begin
            nxt_set[`QPC_IRQ_INDEX] = 1'b1;
        end
        if (index_mode && index_rise && index_reset_enable_ff) begin
            nxt_pos = `QPC_RST_POS;
        end else if (cnt_pulse) begin
            if (match_mode) begin
                // Reset on maximum match going up, reload going down
                if (cnt_up && position_count_ff == maximum_count_ff) begin
                    nxt_pos = `QPC_RST_POS;
                    nxt_set[`QPC_IRQ_MATCH] = 1'b1;
                end else if (!cnt_up && position_count_ff == `QPC_RST_POS) begin
                    nxt_pos = maximum_count_ff;
                    nxt_set[`QPC_IRQ_MATCH] = 1'b1;
                end else begin
                    nxt_pos = stepped;
                end
            end else begin
                // Index modes step freely; passing maximum going up or zero going down flags a count error and its interrupt
                nxt_pos = stepped;
                if (index_mode) begin
                    if ((cnt_up && stepped == max_plus_one) ||
                        (!cnt_up && stepped == `QPC_ALL_ONES)) begin
                        nxt_err = 1'b1;
                        nxt_set[`QPC_IRQ_ERR] = ~count_error_irq_disable_ff;
                    end
                end
            end
        end
    end

    // Control, counter and interrupt registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            encoder_mode_field_ff      <= `QPC_RST_MODE;
            index_reset_enable_ff      <= 1'b0;
            count_error_flag_ff        <= 1'b0;
            count_error_irq_disable_ff <= 1'b0;
            position_count_ff          <= `QPC_RST_POS;
            maximum_count_ff           <= `QPC_RST_MAX;
            irq_status_ff              <= {`QPC_IRQ_W{1'b0}};
            irq_mask_ff                <= {`QPC_IRQ_W{1'b0}};
            irq                        <= 1'b0;
            count_direction            <= 1'b1;
        end else begin
            if (wr_ctrl && wstrb_ff[1]) begin
                encoder_mode_field_ff <= wdata_ff[`QPC_CTRL_MODE_HI:`QPC_CTRL_MODE_LO];
            end
            if (wr_ctrl && wstrb_ff[0]) begin
                index_reset_enable_ff <= wdata_ff[`QPC_CTRL_IRST_BIT];
            end
            // Hardware set wins over a software clear
            if (wr_ctrl && wstrb_ff[1]) begin
                count_error_flag_ff <= wdata_ff[`QPC_CTRL_ERR_BIT] | nxt_err;
            end else if (nxt_err) begin
                count_error_flag_ff <= 1'b1;
            end
            if (wr_filt && wstrb_ff[1]) begin
                count_error_irq_disable_ff <= wdata_ff[`QPC_FILT_COUNT_ERROR_IRQ_DISABLE_BIT];
            end
            position_count_ff <= wr_pos ? merge16(position_count_ff, wdata_ff, wstrb_ff)
                                        : nxt_pos;
            if (wr_max) begin
                maximum_count_ff <= merge16(maximum_count_ff, wdata_ff, wstrb_ff);
            end
            // Write one to clear; a new event in the same cycle stays set
            if (wr_stat && wstrb_ff[0]) begin
                irq_status_ff <= (irq_status_ff & ~wdata_ff[`QPC_IRQ_W-1:0]) | nxt_set;
            end else begin
                irq_status_ff <= irq_status_ff | nxt_set;
            end
            if (wr_mask && wstrb_ff[0]) begin
                irq_mask_ff <= wdata_ff[`QPC_IRQ_W-1:0];
            end
            irq             <= |(irq_status_ff & irq_mask_ff);
            count_direction <= dir_now;
        end
    end

    // AXI4-Lite write channels: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `QPC_RESP_OKAY;
            aw_have_ff    <= 1'b0;
            w_have_ff     <= 1'b0;
            aw_index_ff   <= 4'h0;
            wdata_ff      <= 32'h0000_0000;
            wstrb_ff      <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_ff    <= 1'b1;
                aw_index_ff   <= s_axi_awaddr[5:2];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_ff    <= 1'b1;
                wdata_ff     <= s_axi_wdata;
                wstrb_ff     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_ff   <= 1'b0;
                w_have_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `QPC_RESP_OKAY : `QPC_RESP_SLVERR;
            end
            // Reopen both channels once the response is taken
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channel: one cycle from address to data
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `QPC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= read_reg(s_axi_araddr[5:2]);
                s_axi_rresp   <= idx_known(s_axi_araddr[5:2]) ? `QPC_RESP_OKAY
                                                               : `QPC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the quadrature position counter
`timescale 1ns/1ps
`include "qpc_defs.vh"
module tb_top;
    typedef struct packed {
        logic [2:0]  mode;
        logic        fwd;
        logic [15:0] pos;
        logic        dir;
    } qpc_row_t;
    // Mode, direction, expected position and direction after four states
    qpc_row_t rows [7] = '{
        '{3'h6, 1'h1, 16'h0004, 1'h1},
        '{3'h6, 1'h0, 16'hfffc, 1'h0},
        '{3'h4, 1'h1, 16'h0002, 1'h1},
        '{3'h5, 1'h0, 16'hfffe, 1'h0},
        '{3'h7, 1'h1, 16'h0004, 1'h1},
        '{3'h0, 1'h1, 16'h0000, 1'h0},
        '{3'h3, 1'h0, 16'h0000, 1'h0}};
    logic        aclk = 1'h0, aresetn = 1'h0, step = 1'h0, fwd = 1'h0, mark = 1'h0;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [5:0]  awaddr = 6'h0, araddr = 6'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        awready, wready, bvalid, arready, rvalid, pa, pb, px, dir, irq;
    logic [1:0]  bresp, rresp, last_resp;
    logic [31:0] rdata;
    int          bad_count = 0, check_count = 0, cyc = 0;

    qpc_top u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .phase_a_input(pa), .phase_b_input(pb), .index_input(px),
        .count_direction(dir), .irq(irq));
    qpc_enc_model u_enc (.aclk(aclk), .step(step), .fwd(fwd), .mark(mark),
        .phase_a(pa), .phase_b(pb), .index_out(px));

    // 200 MHz clock and hang guard
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 10000) begin
            bad_count++;
            $display("[ERR] %0t timeout", $time);
            summarize();
        end
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Register write: address and data offered together, each released when taken
    task automatic wr(input logic [3:0] idx, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic aw_ok, w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        @(posedge aclk);
        awaddr <= {idx, 2'h0};
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready === 1'h1) begin
                aw_ok = 1'h1;
                awvalid <= 1'h0;
            end
            if (wvalid && wready === 1'h1) begin
                w_ok = 1'h1;
                wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'h1);
        last_resp = bresp;
        bready <= 1'h0;
    endtask

    // Register read compared against an expected word
    task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
        @(posedge aclk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        last_resp = rresp;
        rready <= 1'h0;
        chk(rdata, exp);
    endtask

    // Encoder states with a chosen gap; index on the last one if asked
    task automatic steps(input int n, input logic f, input logic m, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            step <= 1'h1;
            fwd <= f;
            mark <= m && i == n - 1;
            @(posedge aclk);
            step <= 1'h0;
            repeat (gap) @(posedge aclk);
        end
        repeat (8) @(posedge aclk);
    endtask

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        chk({30'h0, irq, dir}, 32'h1);
        for (int i = 0; i < 6; i++)
            rd(i[3:0], i == 0 ? 32'h800 : (i == 3 ? 32'hffff : 32'h0));
        rd(4'h9, 32'h0);
        chk({30'h0, last_resp}, {30'h0, `QPC_RESP_SLVERR});
        wr(4'h6, 32'h1);
        chk({30'h0, last_resp}, {30'h0, `QPC_RESP_SLVERR});
        $display("test reset done");
        foreach (rows[k]) begin
            wr(`QPC_OFS_CTRL, {21'h0, rows[k].mode, 8'h0});
            wr(`QPC_OFS_POS, 32'h0);
            steps(4, rows[k].fwd, 1'h0, 8);
            rd(`QPC_OFS_POS, {16'h0, rows[k].pos});
            chk({30'h0, last_resp}, {30'h0, `QPC_RESP_OKAY});
            if (rows[k].mode[2])
                chk({31'h0, dir}, {31'h0, rows[k].dir});
        end
        $display("test table done");
        // Upward count error with the interrupt unmasked, fast steps
        wr(`QPC_OFS_STAT, 32'h7);
        chk({30'h0, last_resp}, {30'h0, `QPC_RESP_OKAY});
        wr(`QPC_OFS_CTRL, 32'h0600);
        wr(`QPC_OFS_MAX, 32'h3);
        wr(`QPC_OFS_POS, 32'h2);
        wr(`QPC_OFS_MASK, 32'h1);
        steps(2, 1'h1, 1'h0, 2);
        rd(`QPC_OFS_POS, 32'h4);
        rd(`QPC_OFS_STAT, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(`QPC_OFS_STAT, 32'h1);
        rd(`QPC_OFS_CTRL, 32'h8e00);
        chk({31'h0, irq}, 32'h0);
        wr(`QPC_OFS_CTRL, 32'h0600);
        rd(`QPC_OFS_CTRL, 32'h0e00);
        // Same error with its interrupt disabled
        wr(`QPC_OFS_FILT, 32'h100);
        wr(`QPC_OFS_POS, 32'h2);
        steps(2, 1'h1, 1'h0, 8);
        rd(`QPC_OFS_CTRL, 32'h8e00);
        rd(`QPC_OFS_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test count error done");
        // Match mode: wrap at maximum, no error, masked then unmasked event
        wr(`QPC_OFS_FILT, 32'h0);
        wr(`QPC_OFS_CTRL, 32'h0700);
        wr(`QPC_OFS_POS, 32'h2);
        steps(2, 1'h1, 1'h0, 8);
        rd(`QPC_OFS_POS, 32'h0);
        rd(`QPC_OFS_CTRL, 32'h0f00);
        rd(`QPC_OFS_STAT, 32'h4);
        chk({31'h0, irq}, 32'h0);
        wr(`QPC_OFS_MASK, 32'h4);
        rd(`QPC_OFS_MASK, 32'h4);
        chk({31'h0, irq}, 32'h1);
        wr(`QPC_OFS_STAT, 32'h4);
        rd(`QPC_OFS_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test match done");
        // Index reset on, set through the low byte strobe alone, then off
        wr(`QPC_OFS_MAX, 32'hffff);
        wr(`QPC_OFS_CTRL, 32'h0600);
        wr(`QPC_OFS_CTRL, 32'h0004, 4'h1);
        rd(`QPC_OFS_CTRL, 32'h0e04);
        wr(`QPC_OFS_POS, 32'h10);
        steps(2, 1'h1, 1'h1, 8);
        rd(`QPC_OFS_POS, 32'h0);
        steps(4, 1'h1, 1'h0, 8);
        rd(`QPC_OFS_POS, 32'h4);
        wr(`QPC_OFS_CTRL, 32'h0600);
        steps(4, 1'h1, 1'h1, 8);
        rd(`QPC_OFS_POS, 32'h8);
        // Natural wrap from 0xffff to 0 in an index mode: no error, no event
        wr(`QPC_OFS_MAX, 32'h3);
        wr(`QPC_OFS_POS, 32'hffff);
        wr(`QPC_OFS_STAT, 32'h7);
        steps(1, 1'h1, 1'h0, 8);
        rd(`QPC_OFS_POS, 32'h0);
        rd(`QPC_OFS_STAT, 32'h0);
        $display("test index done");
        // Reset in mid-run
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`QPC_OFS_POS, 32'h0);
        chk({30'h0, irq, dir}, 32'h1);
        $display("test second reset done");
        summarize();
    end
endmodule
